// ==== include/timer16_map.svh ====
// Register offsets, field positions and constants of the 16-bit timer capture/compare block
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// Register byte offsets
`define OFF_CTRL_ONE     8'h00
`define OFF_CTRL_TWO     8'h01
`define OFF_STATUS       8'h02
`define OFF_CAP1_HIGH    8'h03
`define OFF_CAP1_LOW     8'h04
`define OFF_CMP1_HIGH    8'h05
`define OFF_CMP1_LOW     8'h06
`define OFF_CNT_HIGH     8'h07
`define OFF_CNT_LOW      8'h08
`define OFF_ACNT_HIGH    8'h09
`define OFF_ACNT_LOW     8'h0A
`define OFF_CAP2_HIGH    8'h0B
`define OFF_CAP2_LOW     8'h0C
`define OFF_CMP2_HIGH    8'h0D
`define OFF_CMP2_LOW     8'h0E

// Control one fields
`define C1_CAP_IRQ_EN    7
`define C1_CMP_IRQ_EN    6
`define C1_OVF_IRQ_EN    5
`define C1_CAP1_EDGE     1
`define C1_LEVEL2        2
`define C1_LEVEL1        0

// Control two fields
`define C2_OUT1_EN       7
`define C2_OUT2_EN       6
`define C2_ONE_PULSE     5
`define C2_PWM           4
`define C2_CLK_HI        3
`define C2_CLK_LO        2
`define C2_CAP2_EDGE     1
`define C2_EXT_EDGE      0

// Status fields
`define ST_CAP1          7
`define ST_CMP1          6
`define ST_OVF           5
`define ST_CAP2          4
`define ST_CMP2          3

// Reset values
`define CMP_RESET        16'h8000
`define CNT_RESET        16'hFFFC
`define CTRL_RESET       8'h00

// Clock select encodings
`define CLK_DIV4         2'b00
`define CLK_DIV2         2'b01
`define CLK_DIV8         2'b10
`define CLK_EXT          2'b11

`endif

// ==== include/timer16_pkg.sv ====
// Types shared by the 16-bit timer capture/compare block
package timer16_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;
  typedef logic [1:0]  clk_sel_t;
endpackage : timer16_pkg

// ==== rtl/timer16_capture_compare.sv ====
// 16-bit timer: clock select, two input captures, two output compares
//
// Operation
// - Both select bits one picks external clock
// - External edge select chooses rising or falling
// - External events synchronised to rising CPU edge
// - Two read-only split capture registers latch count
// - Per-input capture edge select bits
// - One capture interrupt enable for both inputs
// - Capture sets flag, stores count, requests interrupt
// - Capture flag clears: status read, low access
// - High byte read blocks capture until low read
// - Each capture overwrites with latest count
// - Pulse or PWM mode: only input two
// - Capture pin two always feeds capture logic, pin one not in pulse or PWM mode
// - Compare both registers every timer tick
// - Compare registers software only, reset 8000h
// - Match sets flag, drives level, requests interrupt
// - Output disabled: no pin drive, flag kept
// - Compare flag clears: status read, low access
// - High write suppresses compare until low write
// - Divide-by-two matches equal, others equal plus one
// - Counter low write reloads FFFCh
// - Clock choices divide 2, 4, 8, external
`timescale 1ns/1ps
`include "timer16_map.svh"

module timer16_capture_compare (
  input  wire logic              mclk,         // CPU clock, 100 MHz
  input  wire logic              rst,          // Async reset, active high
  input  wire logic [7:0]        addr,         // Register byte address
  input  wire timer16_pkg::byte_t wdata,       // Write data
  input  wire logic              wr,           // Write strobe
  input  wire logic              rd,           // Read strobe
  output timer16_pkg::byte_t     rdata,        // Read data, cycle after strobe
  input  wire logic              cpu_irq_mask, // CPU interrupt mask bit
  input  wire logic              ext_clock_pin,// External counter clock
  input  wire logic [1:0]        capture_pin,  // Capture inputs 1 and 2
  output logic [1:0]             compare_output_pin, // Compare outputs 1 and 2
  output logic [1:0]             compare_pin_oe,     // Output enables of compare pins
  output logic                   timer_irq     // Timer interrupt request
);
  import timer16_pkg::*;

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  byte_t    control_reg_one;
  byte_t    control_reg_two;
  count_t   counter_reg;
  count_t   cap_value_reg [2];
  count_t   cmp_value_reg [2];
  logic [1:0] cap_flag_reg, cmp_flag_reg, cap_armed_reg, cmp_armed_reg;
  logic [1:0] cap_block_reg, cmp_block_reg;
  logic     ovf_flag_reg, ovf_armed_reg;
  logic [1:0] out_latch_reg;
  logic     ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
  logic [1:0] cap_sync1_reg, cap_sync2_reg, cap_prev_reg;
  logic [2:0] presc_reg;
  logic     fall_phase_reg;
  byte_t    rdata_reg;
  logic     irq_reg;

  clk_sel_t clock_select_field;
  logic     tick, ext_event, pwm_or_opm;
  logic [1:0] cap_edge, cap_event, cmp_hit, cap_low_acc, cmp_low_acc, cap_high_rd, cmp_high_wr;
  logic     status_rd, cnt_low_acc, cnt_low_wr;

  assign clock_select_field = {control_reg_two[`C2_CLK_HI], control_reg_two[`C2_CLK_LO]};
  assign pwm_or_opm = control_reg_two[`C2_PWM] | control_reg_two[`C2_ONE_PULSE];
  assign status_rd   = rd && addr == `OFF_STATUS;
  assign cnt_low_acc = (rd | wr) && addr == `OFF_CNT_LOW;
  assign cnt_low_wr  = wr && (addr == `OFF_CNT_LOW || addr == `OFF_ACNT_LOW);
  assign cap_low_acc = {(rd | wr) && addr == `OFF_CAP2_LOW, (rd | wr) && addr == `OFF_CAP1_LOW};
  assign cmp_low_acc = {(rd | wr) && addr == `OFF_CMP2_LOW, (rd | wr) && addr == `OFF_CMP1_LOW};
  assign cap_high_rd = {rd && addr == `OFF_CAP2_HIGH, rd && addr == `OFF_CAP1_HIGH};
  assign cmp_high_wr = {wr && addr == `OFF_CMP2_HIGH, wr && addr == `OFF_CMP1_HIGH};

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_reg_one <= `CTRL_RESET;
      control_reg_two <= `CTRL_RESET;
    end else if (wr) begin
      if (addr == `OFF_CTRL_ONE) control_reg_one <= wdata;
      if (addr == `OFF_CTRL_TWO) control_reg_two <= wdata;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops before any logic; prev register feeds edge detect
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg  <= 1'b0;
      cap_sync1_reg <= 2'b00;
      cap_sync2_reg <= 2'b00;
      cap_prev_reg  <= 2'b00;
    end else begin
      ext_sync1_reg <= ext_clock_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg  <= ext_sync2_reg;
      cap_sync1_reg <= capture_pin;
      cap_sync2_reg <= cap_sync1_reg;
      cap_prev_reg  <= cap_sync2_reg;
    end
  end

  // ----------------------------------------
  // Timer tick generation
  // ----------------------------------------
  // Falling CPU edges are modelled as a two-phase toggle of the system clock.
  // The prescaler runs from reset and is never cleared by software, so the
  // first internal tick after a clock select change may come early.
  // Trade-off: one shared divider keeps all three rates in step.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_reg      <= 3'd0;
      fall_phase_reg <= 1'b0;
    end else begin
      presc_reg      <= presc_reg + 3'd1;
      fall_phase_reg <= ~fall_phase_reg;
    end
  end

  // Chosen transition of the synchronised external clock
  assign ext_event = control_reg_two[`C2_EXT_EDGE] ? (ext_sync2_reg & ~ext_prev_reg)
                                                   : (~ext_sync2_reg & ext_prev_reg);

  always_comb begin
    unique case (clock_select_field)
      `CLK_DIV2: tick = presc_reg[0];
      `CLK_DIV4: tick = presc_reg[1:0] == 2'b11;
      `CLK_DIV8: tick = presc_reg == 3'b111;
      `CLK_EXT:  tick = ext_event;
    endcase
  end

  // ----------------------------------------
  // Free-running counter
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      counter_reg <= `CNT_RESET;
    else if (cnt_low_wr)
      counter_reg <= `CNT_RESET;
    else if (tick)
      counter_reg <= counter_reg + 16'h0001;
  end

  // Overflow flag, same two-step clear as the others
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_flag_reg  <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else begin
      if (status_rd && ovf_flag_reg) ovf_armed_reg <= 1'b1;
      else if (cnt_low_acc) ovf_armed_reg <= 1'b0;
      if (tick && counter_reg == 16'hFFFF && !cnt_low_wr) ovf_flag_reg <= 1'b1;
      else if (cnt_low_acc && ovf_armed_reg) ovf_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Capture and compare channels
  // ----------------------------------------
  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      logic edge_sel, level_bit, out_en, cmp_match;

      assign edge_sel  = (i == 0) ? control_reg_one[`C1_CAP1_EDGE]
                                  : control_reg_two[`C2_CAP2_EDGE];
      assign level_bit = (i == 0) ? control_reg_one[`C1_LEVEL1] : control_reg_one[`C1_LEVEL2];
      assign out_en    = (i == 0) ? control_reg_two[`C2_OUT1_EN] : control_reg_two[`C2_OUT2_EN];
      assign cap_edge[i]  = edge_sel ? (cap_sync2_reg[i] & ~cap_prev_reg[i])
                                     : (~cap_sync2_reg[i] & cap_prev_reg[i]);
      // Input one belongs to the pulse modes
      assign cap_event[i] = cap_edge[i] && !cap_block_reg[i]
                            && !(i == 0 && pwm_or_opm);
      // Slow clocks see the match one count later.
      // At divide-by-two the match is judged on the count about to be entered, so the flag
      // and pin rise together with the counter reaching the target value.
      // The divide-by-two target is the value itself, the others value plus one.
      // Hazard: judging the old count would flag one tick late.
      assign cmp_match = (clock_select_field == `CLK_DIV2)
                         ? counter_reg + 16'h0001 == cmp_value_reg[i]
                         : counter_reg == cmp_value_reg[i];
      assign cmp_hit[i] = tick && cmp_match && !cmp_block_reg[i];

      // Capture register and high-byte lock
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cap_value_reg[i] <= 16'h0000;
          cap_block_reg[i] <= 1'b0;
        end else begin
          if (cap_event[i]) cap_value_reg[i] <= counter_reg;
          if (cap_high_rd[i]) cap_block_reg[i] <= 1'b1;
          else if (rd && cap_low_acc[i]) cap_block_reg[i] <= 1'b0;
        end
      end

      // Capture flag: set wins over clear
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cap_flag_reg[i]  <= 1'b0;
          cap_armed_reg[i] <= 1'b0;
        end else begin
          if (status_rd && cap_flag_reg[i]) cap_armed_reg[i] <= 1'b1;
          else if (cap_low_acc[i]) cap_armed_reg[i] <= 1'b0;
          if (cap_event[i]) cap_flag_reg[i] <= 1'b1;
          else if (cap_low_acc[i] && cap_armed_reg[i]) cap_flag_reg[i] <= 1'b0;
        end
      end

      // Compare value, written only by software
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cmp_value_reg[i] <= `CMP_RESET;
          cmp_block_reg[i] <= 1'b0;
        end else begin
          if (cmp_high_wr[i]) begin
            cmp_value_reg[i][15:8] <= wdata;
            cmp_block_reg[i]       <= 1'b1;
          end else if (wr && cmp_low_acc[i]) begin
            cmp_value_reg[i][7:0] <= wdata;
            cmp_block_reg[i]      <= 1'b0;
          end
        end
      end

      // Compare flag and output latch
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cmp_flag_reg[i]   <= 1'b0;
          cmp_armed_reg[i]  <= 1'b0;
          out_latch_reg[i]  <= 1'b0;
          compare_pin_oe[i] <= 1'b0;
        end else begin
          if (status_rd && cmp_flag_reg[i]) cmp_armed_reg[i] <= 1'b1;
          else if (cmp_low_acc[i]) cmp_armed_reg[i] <= 1'b0;
          if (cmp_hit[i]) cmp_flag_reg[i] <= 1'b1;
          else if (cmp_low_acc[i] && cmp_armed_reg[i]) cmp_flag_reg[i] <= 1'b0;
          if (cmp_hit[i] && out_en) out_latch_reg[i] <= level_bit;
          compare_pin_oe[i] <= out_en;
        end
      end
    end
  endgenerate

  always_comb compare_output_pin = out_latch_reg;

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // Flags stay pending while the CPU mask is set.
  // The request is a level; it falls once every enabled flag is clear or the CPU mask is set.
  // Registered so the pin never glitches on decode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= !cpu_irq_mask && (
                 (control_reg_one[`C1_CAP_IRQ_EN] && |cap_flag_reg) ||
                 (control_reg_one[`C1_CMP_IRQ_EN] && |cmp_flag_reg) ||
                 (control_reg_one[`C1_OVF_IRQ_EN] && ovf_flag_reg));
  end
  assign timer_irq = irq_reg;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (rd) begin
      unique case (addr)
        `OFF_CTRL_ONE:  rdata_reg <= control_reg_one;
        `OFF_CTRL_TWO:  rdata_reg <= control_reg_two;
        `OFF_STATUS:    rdata_reg <= {cap_flag_reg[0], cmp_flag_reg[0], ovf_flag_reg,
                                      cap_flag_reg[1], cmp_flag_reg[1], 3'b000};
        `OFF_CAP1_HIGH: rdata_reg <= cap_value_reg[0][15:8];
        `OFF_CAP1_LOW:  rdata_reg <= cap_value_reg[0][7:0];
        `OFF_CAP2_HIGH: rdata_reg <= cap_value_reg[1][15:8];
        `OFF_CAP2_LOW:  rdata_reg <= cap_value_reg[1][7:0];
        `OFF_CMP1_HIGH: rdata_reg <= cmp_value_reg[0][15:8];
        `OFF_CMP1_LOW:  rdata_reg <= cmp_value_reg[0][7:0];
        `OFF_CMP2_HIGH: rdata_reg <= cmp_value_reg[1][15:8];
        `OFF_CMP2_LOW:  rdata_reg <= cmp_value_reg[1][7:0];
        `OFF_CNT_HIGH, `OFF_ACNT_HIGH: rdata_reg <= counter_reg[15:8];
        `OFF_CNT_LOW,  `OFF_ACNT_LOW:  rdata_reg <= counter_reg[7:0];
        default:        rdata_reg <= 8'h00;  // Unmapped reads as zero
      endcase
    end else
      rdata_reg <= 8'h00;
  end
  assign rdata = rdata_reg;

endmodule : timer16_capture_compare

// ==== tb/timer16_cc_sva.sv ====
// Port-level assertions for the timer capture/compare block
`timescale 1ns/1ps
`include "timer16_map.svh"

module timer16_cc_sva (
  input wire logic               mclk,               // CPU clock
  input wire logic               rst,                // Async reset
  input wire logic [7:0]         addr,               // Register address
  input wire timer16_pkg::byte_t wdata,              // Write data
  input wire logic               wr,                 // Write strobe
  input wire logic               rd,                 // Read strobe
  input wire timer16_pkg::byte_t rdata,              // Read data
  input wire logic               cpu_irq_mask,       // Interrupt mask
  input wire logic               timer_irq,          // Interrupt request
  input wire logic [1:0]         compare_pin_oe      // Compare pin enables
);
  import timer16_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Shadow of written bytes; hardware must never alter compare values
  byte_t      shadow [16];
  logic [1:0] ctrl2_age;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) shadow[i] <= 8'h00;
      shadow[5] <= 8'h80;
      shadow[13] <= 8'h80;
    end else if (wr && addr < 8'h10) begin
      shadow[addr[3:0]] <= wdata;
    end
  end
  // Age of last control two write, enables lag it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ctrl2_age <= 2'd3;
    else if (wr && addr == `OFF_CTRL_TWO) ctrl2_age <= 2'd0;
    else if (ctrl2_age != 2'd3) ctrl2_age <= ctrl2_age + 2'd1;
  end

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd && addr > `OFF_CMP2_LOW |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_cmp_readback:
    assert property (rd && (addr == `OFF_CMP1_HIGH || addr == `OFF_CMP1_LOW ||
      addr == `OFF_CMP2_HIGH || addr == `OFF_CMP2_LOW) |=> rdata == shadow[$past(addr[3:0])])
    else $error("compare value differs from last write");
  a_oe_follows_ctrl:
    assert property (ctrl2_age >= 2'd2 |->
      compare_pin_oe == {shadow[1][`C2_OUT2_EN], shadow[1][`C2_OUT1_EN]})
    else $error("pin enables differ from control two");
  a_mask_holds_irq: assert property (cpu_irq_mask [*2] |-> !timer_irq)
    else $error("interrupt raised while masked");
  a_irq_rise_unmasked: assert property ($rose(timer_irq) |-> !$past(cpu_irq_mask))
    else $error("interrupt rose under mask");
  a_irq_drop_cause:
    assert property ($fell(timer_irq) |-> $past(cpu_irq_mask) || $past(cpu_irq_mask, 2) ||
      $past(wr || rd) || $past(wr || rd, 2))
    else $error("interrupt fell without access or mask");
  a_cnt_reload:
    assert property (wr && (addr == `OFF_CNT_LOW || addr == `OFF_ACNT_LOW) ##[1:2]
      (rd && addr == `OFF_CNT_HIGH) |=> rdata == 8'hFF)
    else $error("counter not reloaded near FFFC");
endmodule : timer16_cc_sva

bind timer16_capture_compare timer16_cc_sva u_sva (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
  .timer_irq(timer_irq), .compare_pin_oe(compare_pin_oe));

// ==== tb/timer16_pin_source.sv ====
// External clock and capture sources on the timer pins
`timescale 1ns/1ps

module timer16_pin_source (
  input  wire logic mclk,          // CPU clock
  output logic      ext_clock_pin, // Counter clock
  output logic [1:0] capture_pin   // Capture inputs
);
  initial begin
    ext_clock_pin = 1'b0;
    capture_pin = 2'b00;
  end
  // Seventeen CPU cycles per period keeps well under a quarter rate
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge mclk) ext_clock_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      ext_clock_pin <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask : ext_edges
  // Pulse gives both edges so either edge select is served
  task automatic cap_pulse(input int i);
    @(posedge mclk) capture_pin[i] <= 1'b1;
    repeat (8) @(posedge mclk);
    capture_pin[i] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : cap_pulse
endmodule : timer16_pin_source

// ==== tb/timer16_capture_compare_tb_top.sv ====
// Register-level test of the timer capture/compare block
`timescale 1ns/1ps
`include "timer16_map.svh"

module timer16_capture_compare_tb_top;
  import timer16_pkg::*;
  logic       mclk, rst, wr, rd, cpu_irq_mask, ext_clock_pin, timer_irq;
  logic [7:0] addr;
  byte_t      wdata, rdata;
  logic [1:0] capture_pin, compare_output_pin, compare_pin_oe;
  int         fail_count = 0;
  int         n_checks = 0;

  timer16_capture_compare u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
    .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
    .compare_output_pin(compare_output_pin), .compare_pin_oe(compare_pin_oe),
    .timer_irq(timer_irq));
  timer16_pin_source u_src (.mclk(mclk), .ext_clock_pin(ext_clock_pin),
    .capture_pin(capture_pin));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Bus access and compare
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input byte_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // Masked read so unrelated flags do not disturb the result
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string name);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(name, e, rdata & m);
  endtask : rd_chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    cpu_irq_mask = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(`OFF_CMP1_HIGH, 8'hFF, 8'h80, "cmp1 high reset");
    rd_chk(`OFF_CMP2_HIGH, 8'hFF, 8'h80, "cmp2 high reset");
    rd_chk(`OFF_CMP2_LOW, 8'hFF, 8'h00, "cmp2 low reset");
    wr_reg(8'h3F, 8'hA5);
    rd_chk(8'h3F, 8'hFF, 8'h00, "unmapped");
    chk("pins after reset", 8'h00, {4'h0, compare_output_pin, compare_pin_oe});
    wr_reg(`OFF_CTRL_ONE, 8'h02); // Input one rising
    wr_reg(`OFF_CTRL_TWO, 8'h0D); // External rising, input two falling
    wr_reg(`OFF_CNT_LOW, 8'h00);
    rd_chk(`OFF_CNT_HIGH, 8'hFF, 8'hFF, "count high reload");
    u_src.ext_edges(2);
    rd_chk(`OFF_CNT_LOW, 8'hFF, 8'hFE, "external count");
    u_src.cap_pulse(0);
    rd_chk(`OFF_STATUS, 8'h80, 8'h80, "cap1 flag");
    rd_chk(`OFF_CAP1_HIGH, 8'hFF, 8'hFF, "cap1 high");
    rd_chk(`OFF_CAP1_LOW, 8'hFF, 8'hFE, "cap1 low");
    rd_chk(`OFF_STATUS, 8'h80, 8'h00, "cap1 flag cleared");
    rd_chk(`OFF_CAP1_HIGH, 8'hFF, 8'hFF, "cap1 high lock");
    u_src.ext_edges(1);
    u_src.cap_pulse(0);
    rd_chk(`OFF_STATUS, 8'h80, 8'h00, "cap1 blocked flag");
    rd_chk(`OFF_CAP1_LOW, 8'hFF, 8'hFE, "cap1 blocked low");
    u_src.ext_edges(2);
    u_src.cap_pulse(1);
    rd_chk(`OFF_STATUS, 8'h10, 8'h10, "cap2 flag");
    rd_chk(`OFF_CAP2_HIGH, 8'hFF, 8'h00, "cap2 high");
    rd_chk(`OFF_CAP2_LOW, 8'hFF, 8'h01, "cap2 low");
    wr_reg(`OFF_CTRL_TWO, 8'h2D); // One pulse mode on
    u_src.cap_pulse(0);
    u_src.cap_pulse(1);
    rd_chk(`OFF_STATUS, 8'h90, 8'h10, "pulse mode captures");
    rd_chk(`OFF_CAP2_LOW, 8'hFF, 8'h01, "cap2 low again");
    wr_reg(`OFF_CMP1_HIGH, 8'h00);
    wr_reg(`OFF_CMP1_LOW, 8'h03);
    wr_reg(`OFF_CTRL_ONE, 8'h43); // Compare irq, level one high
    wr_reg(`OFF_CTRL_TWO, 8'h8D); // Output one driven
    u_src.ext_edges(2);
    rd_chk(`OFF_STATUS, 8'h40, 8'h00, "no match at value");
    chk("pin before match", 8'h00, {7'h00, compare_output_pin[0]});
    u_src.ext_edges(1);
    rd_chk(`OFF_STATUS, 8'h40, 8'h40, "match at value plus one");
    chk("pins on match", 8'h05, {4'h0, compare_output_pin, compare_pin_oe});
    chk("irq on match", 8'h01, {7'h00, timer_irq});
    @(posedge mclk) cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("irq masked", 8'h00, {7'h00, timer_irq});
    @(posedge mclk) cpu_irq_mask <= 1'b0;
    rd_chk(`OFF_CMP1_LOW, 8'hFF, 8'h03, "cmp1 low");
    rd_chk(`OFF_STATUS, 8'h40, 8'h00, "cmp1 flag cleared");
    conclude();
  end

  // Whole run is a few hundred cycles
  initial begin
    #200us;
    fail_count++;
    conclude();
  end
endmodule : timer16_capture_compare_tb_top
